// >>> rtl/ups_top.sv
// Purpose: per-unit power sequencer, power bus slave and alarm scanner
// Assumes: apb master on mclk; power bus pins asynchronous to mclk
// Notes:   one wait state on every apb access
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ups_cfg.svh"

module ups_top (
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  pcb_clk,
	input  wire logic [`UPS_ADDR_W-1:0] pcb_addr,
	input  wire logic                  pcb_ack_wr,
	input  wire logic                  pcb_oos_wr,
	output logic      [1:0]            pcb_rd_o,
	output logic                       pcb_rd_oe,
	input  wire logic                  on_btn,
	input  wire logic                  off_btn,
	input  wire logic                  manual_override_button,
	input  wire logic                  monitor_test_switch,
	input  wire logic [`UPS_MON_N-1:0] mon_fail,
	input  wire logic                  srua_power_alarm,
	input  wire logic                  disk_major_alarm,
	input  wire logic                  disk_power_alarm,
	output logic                       power_enable,
	output logic                       bus_clamp,
	output logic                       mon_test_force,
	output logic [`UPS_MON_N-1:0]      power_fail_indicator,
	output logic                       unit_alarm_indicator,
	output logic                       off_indicator,
	output logic                       out_of_service_flag,
	output logic                       acknowledge_flag,
	output logic                       ssb_alarm_req,
	output logic                       office_major,
	output logic                       office_minor,
	output logic                       office_dep
);
	import ups_pkg::*;

	localparam int RAMP_CYC = `UPS_RAMP_CYC;
	localparam int SCAN_CYC = `UPS_SCAN_CYC;

	// =================================================================
	// input synchronisers
	logic [`UPS_SYNC_W-1:0] sy;

	ups_sync u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  ({mon_fail, disk_power_alarm, disk_major_alarm, srua_power_alarm,
			monitor_test_switch, manual_override_button, off_btn, on_btn,
			pcb_oos_wr, pcb_ack_wr, pcb_addr, pcb_clk}),
		.dout (sy)
	);

	logic [`UPS_MON_N-1:0]  sy_mon;
	logic [`UPS_ADDR_W-1:0] sy_addr;
	assign sy_mon  = sy[`UPS_SY_MON_LO +: `UPS_MON_N];
	assign sy_addr = sy[`UPS_SY_ADDR_LO +: `UPS_ADDR_W];

	// =================================================================
	// apb slave
	logic [31:0]      ctrl_reg;
	logic [1:0]       esr_reg;
	ups_state_t       state_reg;
	ups_state_t       state_next;
	logic             alarm_reg;
	logic             apb_acc;
	logic             apb_done;
	logic             apb_hit;
	logic [`UPS_ADDR_W-1:0] slot;

	assign apb_acc  = psel && penable;
	assign apb_done = apb_acc && pready;
	assign apb_hit  = (paddr == `UPS_OFF_CTRL) || (paddr == `UPS_OFF_STATUS)
		|| (paddr == `UPS_OFF_ESR);
	assign slot     = ctrl_reg[`UPS_CTRL_SLOT_LO +: `UPS_ADDR_W];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (apb_acc && !pready) begin
			pready  <= 1'b1;
			pslverr <= !apb_hit;
			case (paddr)
				`UPS_OFF_CTRL:   prdata <= ctrl_reg;
				`UPS_OFF_STATUS: prdata <= {22'h00_0000, out_of_service_flag,
					acknowledge_flag, alarm_reg, power_enable, bus_clamp,
					state_reg, pcb_rd_o};
				`UPS_OFF_ESR:    prdata <= {30'h0000_0000, esr_reg};
				default:         prdata <= 32'h0000_0000;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl_reg <= `UPS_CTRL_RESET;
		end else if (apb_done && pwrite && paddr == `UPS_OFF_CTRL) begin
			ctrl_reg <= pwdata;
		end
	end

	// =================================================================
	// office alarm outputs
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			office_major <= 1'b0;
			office_minor <= 1'b0;
			office_dep   <= 1'b0;
		end else begin
			office_major <= ctrl_reg[`UPS_CTRL_OMAJ];
			office_minor <= ctrl_reg[`UPS_CTRL_OMIN];
			office_dep   <= ctrl_reg[`UPS_CTRL_ODEP];
		end
	end

	// =================================================================
	// disk alarm scanner and error source register
	logic [15:0] scan_cnt_reg;
	logic        scan_tick;
	logic [1:0]  esr_set;
	logic [1:0]  esr_clr;

	assign scan_tick = (scan_cnt_reg == 16'(SCAN_CYC - 1));
	assign esr_set[`UPS_ESR_MAJ] = scan_tick && sy[`UPS_SY_DMAJ];
	assign esr_set[`UPS_ESR_PWR] = scan_tick && sy[`UPS_SY_DPWR]
		&& ctrl_reg[`UPS_CTRL_DIAG];
	assign esr_clr = (apb_done && pwrite && paddr == `UPS_OFF_ESR) ? pwdata[1:0] : 2'h0;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			scan_cnt_reg <= 16'h0000;
		end else if (scan_tick) begin
			scan_cnt_reg <= 16'h0000;
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			esr_reg       <= 2'h0;
			ssb_alarm_req <= 1'b0;
		end else begin
			esr_reg       <= esr_set | (esr_reg & ~esr_clr);
			ssb_alarm_req <= |esr_reg;
		end
	end

	// =================================================================
	// power bus slave
	logic clk_d_reg;
	logic bus_tick;
	logic bus_sel;
	logic [1:0] scan_bits;

	assign bus_tick = sy[`UPS_SY_CLK] && !clk_d_reg;
	assign bus_sel  = (sy_addr == slot);

	always_comb begin
		case (state_reg)
			ST_PTEST1: scan_bits = {&sy_mon, |sy_mon};
			ST_PTEST2: scan_bits = {|sy_mon, alarm_reg};
			default:   scan_bits = {power_enable, alarm_reg};
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			clk_d_reg           <= 1'b0;
			out_of_service_flag <= 1'b0;
			acknowledge_flag    <= 1'b0;
			pcb_rd_o            <= 2'h0;
			pcb_rd_oe           <= 1'b0;
		end else begin
			clk_d_reg <= sy[`UPS_SY_CLK];
			if (bus_tick) begin
				pcb_rd_oe <= bus_sel;
				if (bus_sel) begin
					out_of_service_flag <= sy[`UPS_SY_OOS];
					acknowledge_flag    <= sy[`UPS_SY_ACK];
					pcb_rd_o            <= scan_bits;
				end
			end
		end
	end

	// =================================================================
	// sequencer
	logic       fault;
	logic       off_ok;
	logic       par_reg;
	logic       par_err;
	logic [3:0] settle_reg;
	logic [15:0] ramp_cnt_reg;
	logic       test_st;

	assign test_st = (state_reg == ST_MTEST1) || (state_reg == ST_MTEST2)
		|| (state_reg == ST_PTEST1) || (state_reg == ST_PTEST2);
	assign fault   = ((|sy_mon) || sy[`UPS_SY_SRU]) && !test_st && settle_reg == 4'h0
		&& state_reg != ST_OFF;
	assign off_ok  = sy[`UPS_SY_OFF] && (out_of_service_flag || sy[`UPS_SY_MOR]);
	assign par_err = (^state_reg) != par_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (sy[`UPS_SY_ON] && !alarm_reg)
					state_next = ST_RAMP;
			end
			ST_RAMP: begin
				if (ramp_cnt_reg == 16'(RAMP_CYC - 1))
					state_next = out_of_service_flag ? ST_OOS : ST_INSVC;
			end
			ST_INSVC: begin
				if (out_of_service_flag)
					state_next = ST_OOS;
			end
			ST_OOS: begin
				if (acknowledge_flag)
					state_next = ST_PTEST1;
				else if (sy[`UPS_SY_TEST])
					state_next = ST_MTEST1;
				else if (!out_of_service_flag)
					state_next = ST_INSVC;
			end
			ST_MTEST1: begin
				state_next = sy[`UPS_SY_TEST] ? ST_MTEST2 : ST_OOS;
			end
			ST_MTEST2: begin
				if (!sy[`UPS_SY_TEST])
					state_next = ST_OOS;
			end
			ST_PTEST1: begin
				if (!out_of_service_flag && !acknowledge_flag)
					state_next = ST_INSVC;
				else if (bus_tick && bus_sel)
					state_next = ST_PTEST2;
			end
			ST_PTEST2: begin
				if (!out_of_service_flag && !acknowledge_flag)
					state_next = ST_INSVC;
			end
			default: state_next = ST_OFF;
		endcase
		if (state_reg != ST_OFF && (fault || par_err || off_ok))
			state_next = ST_OFF;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg <= ST_OFF;
			par_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			par_reg   <= ^state_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ramp_cnt_reg <= 16'h0000;
		end else if (state_reg == ST_RAMP) begin
			ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
		end else begin
			ramp_cnt_reg <= 16'h0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			settle_reg <= `UPS_SETTLE_CYC;
		end else if (test_st || state_reg == ST_OFF) begin
			settle_reg <= `UPS_SETTLE_CYC;
		end else if (settle_reg != 4'h0) begin
			settle_reg <= settle_reg - 4'h1;
		end
	end

	// =================================================================
	// alarm lamps and power outputs
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			alarm_reg            <= 1'b0;
			power_fail_indicator <= '0;
		end else if (state_reg != ST_OFF && off_ok) begin
			alarm_reg            <= 1'b0;
			power_fail_indicator <= '0;
		end else if (state_next == ST_MTEST1 || state_next == ST_MTEST2) begin
			power_fail_indicator <= '1;
		end else if (state_reg == ST_MTEST2 || state_reg == ST_MTEST1) begin
			power_fail_indicator <= '0;
		end else if (state_reg == ST_OFF && sy[`UPS_SY_OFF]) begin
			alarm_reg            <= 1'b0;
			power_fail_indicator <= '0;
		end else if (fault || par_err) begin
			alarm_reg            <= 1'b1;
			power_fail_indicator <= power_fail_indicator
				| (sy[`UPS_SY_SRU] ? '1 : sy_mon);
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			power_enable         <= 1'b0;
			bus_clamp            <= 1'b1;
			mon_test_force       <= 1'b0;
			off_indicator        <= 1'b1;
			unit_alarm_indicator <= 1'b0;
		end else begin
			power_enable   <= state_next != ST_OFF;
			bus_clamp      <= state_next == ST_OFF || state_next == ST_RAMP;
			mon_test_force <= state_next == ST_MTEST1 || state_next == ST_MTEST2
				|| state_next == ST_PTEST1;
			off_indicator  <= state_next == ST_OFF;
			unit_alarm_indicator <= alarm_reg;
		end
	end

	// =================================================================
	// assertions
	property p_fault_off;
		@(posedge mclk) disable iff (!nrst)
		(fault && !test_st) |=> (state_reg == ST_OFF) && !power_enable;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault did not power down");

	property p_clamp;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_OFF || state_reg == ST_RAMP) |-> bus_clamp;
	endproperty
	a_clamp: assert property (p_clamp) else $error("bus not clamped");

	property p_on_gate;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_OFF && alarm_reg) |=> state_reg == ST_OFF;
	endproperty
	a_on_gate: assert property (p_on_gate) else $error("powered up with alarm");

	property p_off_gate;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_INSVC && !out_of_service_flag && !sy[`UPS_SY_MOR]
			&& !fault && !par_err) |=> state_reg != ST_OFF;
	endproperty
	a_off_gate: assert property (p_off_gate) else $error("off without flag or override");

	property p_mtest_entry;
		@(posedge mclk) disable iff (!nrst)
		$rose(state_reg == ST_MTEST1) |-> $past(state_reg) == ST_OOS;
	endproperty
	a_mtest_entry: assert property (p_mtest_entry) else $error("manual test outside oos");

	property p_mtest_pf;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_MTEST1 || state_reg == ST_MTEST2) |->
			power_fail_indicator == '1;
	endproperty
	a_mtest_pf: assert property (p_mtest_pf) else $error("fail lamps not lit in test");

	property p_release;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_MTEST2 && !sy[`UPS_SY_TEST] && !off_ok) |=>
			state_reg == ST_OOS ##1 power_fail_indicator == '0;
	endproperty
	a_release: assert property (p_release) else $error("test release not handled");

	property p_flags;
		@(posedge mclk) disable iff (!nrst)
		(bus_tick && bus_sel) |=> out_of_service_flag == $past(sy[`UPS_SY_OOS])
			&& acknowledge_flag == $past(sy[`UPS_SY_ACK]);
	endproperty
	a_flags: assert property (p_flags) else $error("flags not taken from bus");

	property p_ptest_end;
		@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_PTEST2 && !out_of_service_flag && !acknowledge_flag && !fault
			&& !par_err && !off_ok) |=> state_reg == ST_INSVC;
	endproperty
	a_ptest_end: assert property (p_ptest_end) else $error("programmed test did not end");

	property p_rd_sel;
		@(posedge mclk) disable iff (!nrst)
		$rose(pcb_rd_oe) |-> $past(bus_tick && bus_sel);
	endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("read lines driven unaddressed");

	property p_diag_only;
		@(posedge mclk) disable iff (!nrst)
		$rose(esr_reg[`UPS_ESR_PWR]) |-> $past(ctrl_reg[`UPS_CTRL_DIAG]);
	endproperty
	a_diag_only: assert property (p_diag_only) else $error("power alarm outside diagnostics");

	c_insvc: cover property (@(posedge mclk) disable iff (!nrst)
		state_reg == ST_RAMP ##1 state_reg == ST_INSVC);
	c_mtest: cover property (@(posedge mclk) disable iff (!nrst)
		state_reg == ST_MTEST2 ##1 state_reg == ST_OOS);
	c_ptest: cover property (@(posedge mclk) disable iff (!nrst)
		state_reg == ST_PTEST2 ##1 state_reg == ST_INSVC);
	c_esr: cover property (@(posedge mclk) disable iff (!nrst) $rose(ssb_alarm_req));
endmodule // ups_top

// >>> rtl/ups_cfg.svh
// Purpose: constants for the unit power sequencer monitor
// Assumes: 125 MHz mclk
// Notes:   offsets are byte addresses on the apb slave
`ifndef UPS_CFG_SVH
`define UPS_CFG_SVH

// =====================================================================
// clock and timing
`define UPS_CLK_MHZ        125
`define UPS_RAMP_NS        2000
`define UPS_RAMP_CYC       ((`UPS_RAMP_NS * `UPS_CLK_MHZ + 999) / 1000)
`define UPS_SCAN_NS        8000
`define UPS_SCAN_CYC       ((`UPS_SCAN_NS * `UPS_CLK_MHZ) / 1000)
`define UPS_SETTLE_CYC     4'h8

// =====================================================================
// widths
`define UPS_MON_N          16
`define UPS_ADDR_W         5
`define UPS_SYNC_W         31

// =====================================================================
// synchroniser bit positions
`define UPS_SY_CLK         0
`define UPS_SY_ADDR_LO     1
`define UPS_SY_ACK         6
`define UPS_SY_OOS         7
`define UPS_SY_ON          8
`define UPS_SY_OFF         9
`define UPS_SY_MOR         10
`define UPS_SY_TEST        11
`define UPS_SY_SRU         12
`define UPS_SY_DMAJ        13
`define UPS_SY_DPWR        14
`define UPS_SY_MON_LO      15

// =====================================================================
// apb registers
`define UPS_OFF_CTRL       8'h00
`define UPS_OFF_STATUS     8'h04
`define UPS_OFF_ESR        8'h08
`define UPS_CTRL_RESET     32'h0000_0000
`define UPS_CTRL_DIAG      0
`define UPS_CTRL_OMAJ      1
`define UPS_CTRL_OMIN      2
`define UPS_CTRL_ODEP      3
`define UPS_CTRL_SLOT_LO   8
`define UPS_ESR_MAJ        0
`define UPS_ESR_PWR        1

`endif

// >>> rtl/ups_pkg.sv
// Purpose: types for the unit power sequencer monitor
// Assumes: nothing
// Notes:   state parity is taken over the enum encoding
package ups_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_RAMP,
		ST_INSVC,
		ST_OOS,
		ST_MTEST1,
		ST_MTEST2,
		ST_PTEST1,
		ST_PTEST2
	} ups_state_t;
endpackage

// >>> rtl/ups_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes:   output bit changes once stages two and three agree
`timescale 1ns/1ps
`include "ups_cfg.svh"

module ups_sync (
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	input  wire logic [`UPS_SYNC_W-1:0] din,
	output logic      [`UPS_SYNC_W-1:0] dout
);
	import ups_pkg::*;

	logic [`UPS_SYNC_W-1:0] s1_reg;
	logic [`UPS_SYNC_W-1:0] s2_reg;
	logic [`UPS_SYNC_W-1:0] s3_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// =================================================================
	// agreement filter per bit
	genvar gi;
	generate
		for (gi = 0; gi < `UPS_SYNC_W; gi++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					dout[gi] <= 1'b0;
				end else if (s2_reg[gi] == s3_reg[gi]) begin
					dout[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate
endmodule // ups_sync

// >>> verif/ups_pcb_master.sv
// Purpose: main processor end of the power bus, one addressed tick a call
// Assumes: link clock period 125 ns, still between polls
// Notes:   undriven read leads read as inverse of the last driven level
`timescale 1ns/1ps

module ups_pcb_master (
	output logic            pcb_clk,
	output logic [4:0]      pcb_addr,
	output logic            pcb_ack_wr,
	output logic            pcb_oos_wr,
	input  wire logic [1:0] pcb_rd_o,
	input  wire logic       pcb_rd_oe
);
	logic [1:0] rd_last = 2'h0;
	wire  [1:0] rd_line = pcb_rd_oe ? pcb_rd_o : ~rd_last;

	initial begin
		pcb_clk = 1'h0;
		pcb_addr = 5'h1f;
		pcb_ack_wr = 1'h0;
		pcb_oos_wr = 1'h0;
	end

	always @(posedge pcb_clk) begin
		if (pcb_rd_oe)
			rd_last <= pcb_rd_o;
	end

	// leads set half a period before the rise, held through the tick
	task automatic poll(input logic [4:0] a, input logic ack, input logic out_of_service_state,
		output logic [1:0] rd);
		pcb_addr = a;
		pcb_ack_wr = ack;
		pcb_oos_wr = out_of_service_state;
		#62.5 pcb_clk = 1'h1;
		#62.5 rd = rd_line;
		pcb_clk = 1'h0;
	endtask
endmodule // ups_pcb_master

// >>> verif/ups_top_tb.sv
// Purpose: self-checking bench for ups_top
// Assumes: power bus driven by ups_pcb_master
// Notes:   monitors modelled as failing while forced into test
`timescale 1ns/1ps
`include "ups_cfg.svh"

module unit_power_sequencer_monitor_tb_top;
	import ups_pkg::*;
	logic                   mclk, nrst, psel, penable, pwrite;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, q;
	logic                   pready, pslverr, e, pcb_rd_oe;
	wire                    pcb_clk, pcb_ack_wr, pcb_oos_wr;
	wire  [`UPS_ADDR_W-1:0] pcb_addr;
	logic [1:0]             pcb_rd_o, rd;
	logic                   on_btn, off_btn, manual_override_button, monitor_test_switch;
	logic [15:0]            mon_fail = 16'h0;
	logic [15:0]            fault_mask, power_fail_indicator;
	logic                   srua_power_alarm, disk_major_alarm, disk_power_alarm;
	logic                   power_enable, bus_clamp, mon_test_force, unit_alarm_indicator;
	logic                   off_indicator, out_of_service_flag, acknowledge_flag;
	logic                   ssb_alarm_req, office_major, office_minor, office_dep;
	int                     fail_count = 0;
	int                     checks = 0;

	ups_top dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pcb_clk, .pcb_addr, .pcb_ack_wr, .pcb_oos_wr, .pcb_rd_o, .pcb_rd_oe,
		.on_btn, .off_btn, .manual_override_button, .monitor_test_switch, .mon_fail,
		.srua_power_alarm, .disk_major_alarm, .disk_power_alarm, .power_enable, .bus_clamp,
		.mon_test_force, .power_fail_indicator, .unit_alarm_indicator, .off_indicator,
		.out_of_service_flag, .acknowledge_flag, .ssb_alarm_req, .office_major,
		.office_minor, .office_dep);
	ups_pcb_master cpu (.pcb_clk, .pcb_addr, .pcb_ack_wr, .pcb_oos_wr, .pcb_rd_o, .pcb_rd_oe);

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk)
		mon_fail <= fault_mask | {16{mon_test_force}};

	// =====================================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1);
		chk(32'(n), 32'h2, "apb wait state");
		rq = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic chk_state(input ups_state_t exp);
		apb(1'h0, `UPS_OFF_STATUS, 32'h0, q, e);
		chk({29'h0, q[4:2]}, {29'h0, exp}, "state");
	endtask

	task automatic push(input logic on_p, input logic off_p);
		on_btn <= on_p;
		off_btn <= off_p;
		cyc(8);
		on_btn <= 1'h0;
		off_btn <= 1'h0;
		cyc(8);
	endtask

	task automatic power_up();
		push(1'h1, 1'h0);
		cyc(260);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// =====================================================================
	// scenarios
	task automatic t_reset();
		@(posedge mclk);
		chk(32'({bus_clamp, off_indicator, power_enable}), 32'h6, "reset outputs");
		chk_state(ST_OFF);
		push(1'h1, 1'h0);
		cyc(200);
		chk(32'({bus_clamp, power_enable}), 32'h3, "ramping");
		chk_state(ST_RAMP);
		cyc(60);
		chk(32'({bus_clamp, power_enable}), 32'h1, "powered");
		chk_state(ST_INSVC);
		$display("t_reset done");
	endtask

	task automatic t_apb();
		apb(1'h1, `UPS_OFF_CTRL, 32'h0000_030e, q, e);
		cyc(2);
		chk(32'({office_major, office_minor, office_dep}), 32'h7, "office");
		apb(1'h0, 8'h0c, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1, "unmapped");
		monitor_test_switch <= 1'h1;
		cyc(20);
		chk(32'(power_fail_indicator), 32'h0, "switch in service");
		chk_state(ST_INSVC);
		monitor_test_switch <= 1'h0;
		cyc(10);
		$display("t_apb done");
	endtask

	task automatic t_poll();
		cpu.poll(5'h05, 1'h0, 1'h1, rd);
		chk(32'({out_of_service_flag, pcb_rd_oe}), 32'h0, "other slot");
		cpu.poll(5'h03, 1'h0, 1'h0, rd);
		chk(32'({pcb_rd_oe, rd}), 32'h6, "status scan");
		cpu.poll(5'h03, 1'h0, 1'h1, rd);
		chk(32'(out_of_service_flag), 32'h1, "oos flag");
		chk_state(ST_OOS);
		$display("t_poll done");
	endtask

	task automatic t_manual();
		monitor_test_switch <= 1'h1;
		cyc(40);
		chk(32'(power_fail_indicator), 32'hffff, "test lamps");
		chk_state(ST_MTEST2);
		monitor_test_switch <= 1'h0;
		cyc(10);
		chk(32'(power_fail_indicator), 32'h0, "lamps out");
		chk_state(ST_OOS);
		$display("t_manual done");
	endtask

	task automatic t_prog();
		cpu.poll(5'h03, 1'h1, 1'h1, rd);
		chk(32'({acknowledge_flag, mon_test_force}), 32'h3, "ack flag and force");
		chk_state(ST_PTEST1);
		cpu.poll(5'h03, 1'h1, 1'h1, rd);
		chk(32'(rd), 32'h3, "test scan");
		chk_state(ST_PTEST2);
		cpu.poll(5'h03, 1'h0, 1'h0, rd);
		chk(32'({out_of_service_flag, acknowledge_flag}), 32'h0, "flags");
		chk_state(ST_INSVC);
		$display("t_prog done");
	endtask

	task automatic t_off_fault();
		push(1'h0, 1'h1);
		chk(32'(power_enable), 32'h1, "off refused");
		manual_override_button <= 1'h1;
		push(1'h0, 1'h1);
		manual_override_button <= 1'h0;
		chk(32'({power_enable, off_indicator}), 32'h1, "override off");
		power_up();
		fault_mask <= 16'h0020;
		cyc(12);
		chk(32'({power_enable, bus_clamp, unit_alarm_indicator}), 32'h3, "fault");
		chk(32'(power_fail_indicator), 32'h0020, "fault lamp");
		fault_mask <= 16'h0;
		push(1'h1, 1'h0);
		chk(32'(power_enable), 32'h0, "on with alarm");
		push(1'h0, 1'h1);
		chk({15'h0, unit_alarm_indicator, power_fail_indicator}, 32'h0, "cleared");
		power_up();
		srua_power_alarm <= 1'h1;
		cyc(12);
		chk(32'({power_enable, unit_alarm_indicator}), 32'h1, "speech alarm");
		srua_power_alarm <= 1'h0;
		push(1'h0, 1'h1);
		$display("t_off_fault done");
	endtask

	task automatic t_esr();
		disk_major_alarm <= 1'h1;
		disk_power_alarm <= 1'h1;
		cyc(1100);
		apb(1'h0, `UPS_OFF_ESR, 32'h0, q, e);
		chk(q, 32'h1, "esr no diag");
		chk(32'(ssb_alarm_req), 32'h1, "forward");
		apb(1'h1, `UPS_OFF_CTRL, 32'h0000_0301, q, e);
		cyc(1100);
		apb(1'h0, `UPS_OFF_ESR, 32'h0, q, e);
		chk(q, 32'h3, "esr diag");
		disk_major_alarm <= 1'h0;
		disk_power_alarm <= 1'h0;
		apb(1'h1, `UPS_OFF_CTRL, 32'h0000_0300, q, e);
		cyc(10);
		apb(1'h1, `UPS_OFF_ESR, 32'h3, q, e);
		apb(1'h0, `UPS_OFF_ESR, 32'h0, q, e);
		chk({q[30:0], ssb_alarm_req}, 32'h0, "esr cleared");
		$display("t_esr done");
	endtask

	// =====================================================================
	// main sequence and watchdog
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{on_btn, off_btn, manual_override_button, monitor_test_switch} = '0;
		{fault_mask, srua_power_alarm, disk_major_alarm, disk_power_alarm} = '0;
		repeat (4) @(posedge mclk);
		nrst <= 1'h1;
		t_reset();
		t_apb();
		t_poll();
		t_manual();
		cpu.poll(5'h03, 1'h0, 1'h0, rd);
		cpu.poll(5'h03, 1'h0, 1'h1, rd);
		t_prog();
		t_off_fault();
		t_esr();
		tally_and_finish();
	end

	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
endmodule // unit_power_sequencer_monitor_tb_top
